// file: src/smr_defines.vh
`ifndef SMR_DEFINES_VH
`define SMR_DEFINES_VH
// register byte offsets
`define SMR_MODE_OFF      12'h000
`define SMR_CMD_OFF       12'h004
`define SMR_IRQ_OFF       12'h008
`define SMR_STATE_OFF     12'h00C
`define SMR_PORT_OFF      12'h010
`define SMR_DHW_HI_OFF    12'h014
`define SMR_DHW_LO_OFF    12'h018
`define SMR_DIP_OFF       12'h01C
`define SMR_DPORT_OFF     12'h020
`define SMR_PROTO_OFF     12'h024
`define SMR_TXFREE_OFF    12'h028
`define SMR_TXWR_OFF      12'h02C
`define SMR_RXSIZE_OFF    12'h030
`define SMR_TXLEN_OFF     12'h034
`define SMR_RXDROP_OFF    12'h038
`define SMR_MSGCNT_OFF    12'h03C
// mode fields
`define SMR_MODE_MULTI_BIT 7
`define SMR_PROTO_CLOSED  4'h0
`define SMR_PROTO_TCP     4'h1
`define SMR_PROTO_UDP     4'h2
`define SMR_PROTO_IPRAW   4'h3
`define SMR_PROTO_MACRAW  4'h4
// commands
`define SMR_CMD_OPEN      8'h01
`define SMR_CMD_CLOSE     8'h10
`define SMR_CMD_SEND      8'h20
`define SMR_CMD_RECV      8'h40
// socket states
`define SMR_ST_CLOSED     8'h00
`define SMR_ST_UDP        8'h22
`define SMR_ST_IPRAW      8'h32
`define SMR_ST_MACRAW     8'h42
// interrupt flag bits
`define SMR_IRQ_RECV_BIT  2
`define SMR_IRQ_SEND_BIT  4
// protocol numbers
`define SMR_IPP_ICMP      8'h01
`define SMR_IPP_IGMP      8'h02
`define SMR_IPP_TCP       8'h06
`define SMR_IPP_UDP       8'h11
// group message kinds
`define SMR_MSG_JOIN      2'h1
`define SMR_MSG_LEAVE     2'h2
`define SMR_MSG_REPORT    2'h3
// rx header size and buffer size
`define SMR_RX_HDR_BYTES  16'h0006
`define SMR_TX_BUF_BYTES  16'h0800
`define SMR_RX_BUF_BYTES  16'h0800
// report period in ms and cycles at 100 MHz
`define SMR_REPORT_MS     10
`define SMR_CLK_KHZ       100000
`define SMR_REPORT_CYC    (`SMR_REPORT_MS * `SMR_CLK_KHZ)
`endif

// file: src/smr_group_msg.v
`timescale 1ns/1ps
`include "smr_defines.vh"
// group messaging: join on open, leave on close, periodic report
module smr_group_msg #(
  parameter REPORT_CYC = `SMR_REPORT_CYC  // report period in cycles
) (
  input  wire        pclk,       // system clock
  input  wire        presetn,    // async reset, active low
  input  wire        join_req,   // pulse: multicast socket opened
  input  wire        leave_req,  // pulse: multicast socket closed
  input  wire        active,     // multicast socket open
  input  wire        msg_ready,  // mac accepts a message
  output reg         msg_valid,  // message request pending
  output reg  [1:0]  msg_kind    // join, leave or report
);
  reg [31:0] timer;              // report period counter
  reg        pend_join;          // join waiting
  reg        pend_leave;         // leave waiting
  reg        pend_rep;           // report waiting

  // pending flags; request wins over a same-cycle drain
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer      <= 32'h0;
      pend_join  <= 1'b0;
      pend_leave <= 1'b0;
      pend_rep   <= 1'b0;
      msg_valid  <= 1'b0;
      msg_kind   <= 2'h0;
    end else begin
      // report timer runs only while the group is joined
      if (!active || timer >= REPORT_CYC - 1)
        timer <= 32'h0;
      else
        timer <= timer + 32'h1;
      if (msg_valid && msg_ready) begin
        msg_valid <= 1'b0;
      end else if (!msg_valid) begin
        // priority: leave, join, report
        if (pend_leave) begin
          msg_valid  <= 1'b1;
          msg_kind   <= `SMR_MSG_LEAVE;
          pend_leave <= leave_req;
        end else if (pend_join) begin
          msg_valid <= 1'b1;
          msg_kind  <= `SMR_MSG_JOIN;
          pend_join <= join_req;
        end else if (pend_rep) begin
          msg_valid <= 1'b1;
          msg_kind  <= `SMR_MSG_REPORT;
          pend_rep  <= 1'b0;
        end
      end
      if (join_req)
        pend_join <= 1'b1;
      if (leave_req) begin
        pend_leave <= 1'b1;
        pend_join  <= 1'b0;
        pend_rep   <= 1'b0;               // no report once the group is left
      end
      if (active && timer >= REPORT_CYC - 1)
        pend_rep <= 1'b1;
    end
  end
endmodule // smr_group_msg

// file: src/smr_socket.v
`timescale 1ns/1ps
`include "smr_defines.vh"
// one socket's multicast, ip raw and mac raw control over apb
module smr_socket #(
  parameter REPORT_CYC = `SMR_REPORT_CYC,  // report period in cycles
  parameter SOCKET_ID  = 0                 // socket index, mac raw only on 0
) (
  input  wire        pclk,          // system clock
  input  wire        presetn,       // async reset, active low
  input  wire        psel,          // apb select
  input  wire        penable,       // apb access phase
  input  wire        pwrite,        // apb write
  input  wire [11:0] paddr,         // apb byte address
  input  wire [31:0] pwdata,        // apb write data
  output reg  [31:0] prdata,        // apb read data
  output wire        pready,        // apb ready, always one
  output wire        pslverr,       // apb error on unmapped address
  output reg         tx_start,      // pulse: frame send begins
  output reg  [7:0]  tx_proto,      // ip protocol field for send
  output reg  [47:0] tx_dest_hw,    // destination hw address for send
  output reg  [31:0] tx_dest_ip,    // destination ip for send
  output reg  [15:0] tx_dest_port,  // destination port for send
  output reg  [15:0] tx_len,        // send length in bytes
  output reg         tx_raw_frame,  // send frame as is, no headers
  input  wire        tx_done,       // pulse: send finished
  input  wire        rx_valid,      // pulse: received packet offered
  input  wire [7:0]  rx_proto,      // its ip protocol number
  input  wire [31:0] rx_src_ip,     // its sender ip
  input  wire [15:0] rx_len,        // its data length
  input  wire        rx_fragment,   // it is a fragment
  output reg         rx_accept,     // pulse: packet taken into rx buffer
  output reg  [47:0] rx_header,     // header stored before the data
  output wire        grp_valid,     // group message request
  output wire [1:0]  grp_kind,      // group message kind
  input  wire        grp_ready      // mac accepts group message
);
  reg  [7:0]  socket_mode_reg;      // mode: multicast bit, protocol
  reg  [7:0]  socket_state_reg;     // socket state
  reg  [7:0]  socket_interrupt_flags; // sticky event flags
  reg  [15:0] source_port_number;   // source port
  reg  [47:0] dest_hw_address;      // destination hw address
  reg  [31:0] dest_ip_address;      // destination ip
  reg  [15:0] dest_port_number;     // destination port
  reg  [7:0]  ip_protocol_number;   // ip raw protocol
  reg  [15:0] tx_write_pointer;     // host write pointer
  reg  [15:0] tx_read_pointer;      // send progress pointer
  reg  [15:0] rx_used;              // bytes in rx buffer
  reg  [15:0] rx_drop_count;        // dropped packet count
  reg  [15:0] msg_count;            // group messages sent
  reg         sending;              // send in progress
  reg         join_pulse;           // open of a multicast socket
  reg         leave_pulse;          // close of a multicast socket
  wire [15:0] tx_free_size;         // free tx bytes
  wire [15:0] rx_free;              // free rx bytes
  wire        wr_en;                // apb write strobe
  wire        cmd_wr;               // command register written
  wire [7:0]  cmd;                  // command byte
  wire        rx_ok;                // packet passes filter and fits
  wire        is_multi;             // socket open as multicast
  wire [3:0]  protocol_select_field; // mode protocol field

  // address decode shared by write strobe and error
  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `SMR_MSGCNT_OFF);
    end
  endfunction

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign wr_en   = psel & penable & pwrite & mapped(paddr);
  assign cmd_wr  = wr_en && (paddr == `SMR_CMD_OFF);
  assign cmd     = pwdata[7:0];
  assign protocol_select_field = socket_mode_reg[3:0];
  assign is_multi = (socket_state_reg == `SMR_ST_UDP) &&
                    socket_mode_reg[`SMR_MODE_MULTI_BIT];
  assign tx_free_size = `SMR_TX_BUF_BYTES - (tx_write_pointer - tx_read_pointer);
  assign rx_free = `SMR_RX_BUF_BYTES - rx_used;
  // ip raw filter, tcp and udp numbers never served
  assign rx_ok = (socket_state_reg == `SMR_ST_IPRAW) &&
                 (ip_protocol_number != `SMR_IPP_TCP) &&
                 (ip_protocol_number != `SMR_IPP_UDP) &&
                 (rx_proto == ip_protocol_number) &&
                 !rx_fragment &&
                 ({16'h0, rx_len} + {16'h0, `SMR_RX_HDR_BYTES}
                  <= {16'h0, rx_free});

  // register writes, commands and state transitions
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      socket_mode_reg    <= 8'h00;
      socket_state_reg   <= `SMR_ST_CLOSED;
      source_port_number <= 16'h0000;
      dest_hw_address    <= 48'h0;
      dest_ip_address    <= 32'h0;
      dest_port_number   <= 16'h0000;
      ip_protocol_number <= 8'h00;
      tx_write_pointer   <= 16'h0000;
      tx_read_pointer    <= 16'h0000;
      sending            <= 1'b0;
      join_pulse         <= 1'b0;
      leave_pulse        <= 1'b0;
      tx_start           <= 1'b0;
      tx_proto           <= 8'h00;
      tx_dest_hw         <= 48'h0;
      tx_dest_ip         <= 32'h0;
      tx_dest_port       <= 16'h0000;
      tx_len             <= 16'h0000;
      tx_raw_frame       <= 1'b0;
    end else begin
      join_pulse  <= 1'b0;
      leave_pulse <= 1'b0;
      tx_start    <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `SMR_MODE_OFF:   socket_mode_reg <= pwdata[7:0];
          `SMR_PORT_OFF:   source_port_number <= pwdata[15:0];
          `SMR_DHW_HI_OFF: dest_hw_address[47:32] <= pwdata[15:0];
          `SMR_DHW_LO_OFF: dest_hw_address[31:0] <= pwdata;
          `SMR_DIP_OFF:    dest_ip_address <= pwdata;
          `SMR_DPORT_OFF:  dest_port_number <= pwdata[15:0];
          `SMR_PROTO_OFF:  ip_protocol_number <= pwdata[7:0];
          `SMR_TXWR_OFF:   tx_write_pointer <= pwdata[15:0];
          default: ;
        endcase
      end
      if (cmd_wr && cmd == `SMR_CMD_OPEN &&
          socket_state_reg == `SMR_ST_CLOSED) begin
        case (protocol_select_field)
          `SMR_PROTO_UDP: begin
            socket_state_reg <= `SMR_ST_UDP;
            if (socket_mode_reg[`SMR_MODE_MULTI_BIT])
              join_pulse <= 1'b1;
          end
          `SMR_PROTO_IPRAW:
            if (ip_protocol_number != `SMR_IPP_TCP &&
                ip_protocol_number != `SMR_IPP_UDP)
              socket_state_reg <= `SMR_ST_IPRAW;
          `SMR_PROTO_MACRAW:
            if (SOCKET_ID == 0)
              socket_state_reg <= `SMR_ST_MACRAW;
          default: ;
        endcase
      end else if (cmd_wr && cmd == `SMR_CMD_CLOSE) begin
        if (is_multi)
          leave_pulse <= 1'b1;
        socket_state_reg <= `SMR_ST_CLOSED;
        sending          <= 1'b0;
      end else if (cmd_wr && cmd == `SMR_CMD_SEND && !sending &&
                   socket_state_reg != `SMR_ST_CLOSED &&
                   tx_write_pointer != tx_read_pointer) begin
        // send uses stored destination, no rewrite needed
        sending      <= 1'b1;
        tx_start     <= 1'b1;
        tx_len       <= tx_write_pointer - tx_read_pointer;
        tx_dest_hw   <= dest_hw_address;
        tx_dest_ip   <= dest_ip_address;
        tx_dest_port <= dest_port_number;
        tx_proto     <= ip_protocol_number;
        tx_raw_frame <= (socket_state_reg == `SMR_ST_MACRAW);
      end
      if (sending && tx_done) begin
        sending         <= 1'b0;
        tx_read_pointer <= tx_read_pointer + tx_len;
      end
    end
  end

  // sticky flags: hardware set wins over write-one clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      socket_interrupt_flags <= 8'h00;
    end else begin
      if (wr_en && paddr == `SMR_IRQ_OFF)
        socket_interrupt_flags <= socket_interrupt_flags & ~pwdata[7:0];
      if (sending && tx_done)
        socket_interrupt_flags[`SMR_IRQ_SEND_BIT] <= 1'b1;
      if (rx_valid && rx_ok)
        socket_interrupt_flags[`SMR_IRQ_RECV_BIT] <= 1'b1;
    end
  end

  // receive path: accept into buffer with header or drop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_used       <= 16'h0000;
      rx_accept     <= 1'b0;
      rx_header     <= 48'h0;
      rx_drop_count <= 16'h0000;
    end else begin
      rx_accept <= 1'b0;
      if (rx_valid && rx_ok) begin
        rx_accept <= 1'b1;
        rx_header <= {rx_src_ip, rx_len};
        rx_used   <= rx_used + rx_len + `SMR_RX_HDR_BYTES;
      end else if (rx_valid && socket_state_reg == `SMR_ST_IPRAW) begin
        rx_drop_count <= rx_drop_count + 16'h1;
      end else if (cmd_wr && cmd == `SMR_CMD_RECV) begin
        rx_used <= 16'h0000;  // host drained the buffer
      end
      if (cmd_wr && cmd == `SMR_CMD_CLOSE)
        rx_used <= 16'h0000;
    end
  end

  // count group messages handed to the mac
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      msg_count <= 16'h0000;
    else if (grp_valid && grp_ready)
      msg_count <= msg_count + 16'h1;
  end

  // apb read mux
  always @* begin
    case (paddr)
      `SMR_MODE_OFF:   prdata = {24'h0, socket_mode_reg};
      `SMR_IRQ_OFF:    prdata = {24'h0, socket_interrupt_flags};
      `SMR_STATE_OFF:  prdata = {24'h0, socket_state_reg};
      `SMR_PORT_OFF:   prdata = {16'h0, source_port_number};
      `SMR_DHW_HI_OFF: prdata = {16'h0, dest_hw_address[47:32]};
      `SMR_DHW_LO_OFF: prdata = dest_hw_address[31:0];
      `SMR_DIP_OFF:    prdata = dest_ip_address;
      `SMR_DPORT_OFF:  prdata = {16'h0, dest_port_number};
      `SMR_PROTO_OFF:  prdata = {24'h0, ip_protocol_number};
      `SMR_TXFREE_OFF: prdata = {16'h0, tx_free_size};
      `SMR_TXWR_OFF:   prdata = {16'h0, tx_write_pointer};
      `SMR_RXSIZE_OFF: prdata = {16'h0, rx_used};
      `SMR_TXLEN_OFF:  prdata = {16'h0, tx_len};
      `SMR_RXDROP_OFF: prdata = {16'h0, rx_drop_count};
      `SMR_MSGCNT_OFF: prdata = {16'h0, msg_count};
      default:         prdata = 32'h0;
    endcase
  end

  // ping stays in hardware outside this socket, group messaging runs in u_group inside it
  // internal group messaging covers versions 1 and 2 only
  smr_group_msg #(
    .REPORT_CYC (REPORT_CYC)
  ) u_group (
    .pclk      (pclk),
    .presetn   (presetn),
    .join_req  (join_pulse),
    .leave_req (leave_pulse),
    .active    (is_multi),
    .msg_ready (grp_ready),
    .msg_valid (grp_valid),
    .msg_kind  (grp_kind)
  );
endmodule // smr_socket

// file: testbench/smr_socket_properties.sv
`timescale 1ns/1ps
`include "smr_defines.vh"
// watches the bus, send, receive and group message ports of one socket
module smr_socket_properties #(
  parameter REPORT_CYC = `SMR_REPORT_CYC  // report period in cycles
) (
  input logic        pclk,         // clock
  input logic        presetn,      // reset, active low
  input logic        psel,         // apb select
  input logic        penable,      // apb access
  input logic        pwrite,       // apb write
  input logic [11:0] paddr,        // apb address
  input logic [31:0] pwdata,       // apb write data
  input logic        pready,       // apb ready
  input logic        tx_start,     // send begins
  input logic [31:0] tx_dest_ip,   // send destination
  input logic        rx_valid,     // packet offered
  input logic [7:0]  rx_proto,     // its protocol
  input logic        rx_fragment,  // it is a fragment
  input logic        rx_accept,    // packet taken
  input logic        grp_valid,    // group message pending
  input logic [1:0]  grp_kind,     // its kind
  input logic        grp_ready     // message taken
);
  logic        wr_take;   // write taken at this edge
  logic        open_wr;   // open command written
  logic        close_wr;  // close command written
  logic        send_wr;   // send command written
  logic [7:0]  mode_q;    // last mode written
  logic [7:0]  proto_q;   // last protocol number written
  logic [31:0] dip_q;     // last destination ip written
  logic        closed_q;  // socket believed closed
  logic        mc_q;      // multicast socket open
  int          gap;       // cycles without group message while open
  assign wr_take  = psel & penable & pwrite & pready;
  assign open_wr  = wr_take && paddr == `SMR_CMD_OFF && pwdata[7:0] == `SMR_CMD_OPEN;
  assign close_wr = wr_take && paddr == `SMR_CMD_OFF && pwdata[7:0] == `SMR_CMD_CLOSE;
  assign send_wr  = wr_take && paddr == `SMR_CMD_OFF && pwdata[7:0] == `SMR_CMD_SEND;
  // shadow what the properties need to know
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mode_q, proto_q, dip_q, mc_q, gap} <= '0;
      closed_q <= 1'b1;
    end else begin
      if (wr_take && paddr == `SMR_MODE_OFF) mode_q <= pwdata[7:0];
      if (wr_take && paddr == `SMR_PROTO_OFF) proto_q <= pwdata[7:0];
      if (wr_take && paddr == `SMR_DIP_OFF) dip_q <= pwdata;
      if (open_wr) closed_q <= 1'b0;
      if (close_wr) closed_q <= 1'b1;
      if (open_wr && closed_q && mode_q == 8'h82) mc_q <= 1'b1;
      if (close_wr) mc_q <= 1'b0;
      gap <= (mc_q && !grp_valid) ? gap + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_join;
    open_wr && closed_q && mode_q == 8'h82 |-> ##[1:8] (grp_valid && grp_kind == `SMR_MSG_JOIN);
  endproperty
  a_join: assert property (p_join) else $error("no join after multicast open");
  property p_leave;
    close_wr && mc_q |-> ##[1:8] (grp_valid && grp_kind == `SMR_MSG_LEAVE);
  endproperty
  a_leave: assert property (p_leave) else $error("no leave after close");
  property p_hold;
    grp_valid && !grp_ready |=> grp_valid && $stable(grp_kind);
  endproperty
  a_hold: assert property (p_hold) else $error("group message dropped");
  property p_report;
    mc_q |-> gap <= REPORT_CYC + 8;
  endproperty
  a_report: assert property (p_report) else $error("report overdue");
  property p_txstart;
    $rose(tx_start) |-> $past(send_wr);
  endproperty
  a_txstart: assert property (p_txstart) else $error("send began unasked");
  property p_dest;
    $rose(tx_start) && mc_q |-> tx_dest_ip == dip_q;
  endproperty
  a_dest: assert property (p_dest) else $error("send not to group");
  property p_filter;
    rx_accept |-> $past(rx_valid) && $past(rx_proto) == proto_q && !$past(rx_fragment);
  endproperty
  a_filter: assert property (p_filter) else $error("foreign packet taken");
  property p_frag;
    rx_valid && rx_fragment |=> !rx_accept;
  endproperty
  a_frag: assert property (p_frag) else $error("fragment taken");
  c_report: cover property (mc_q && grp_valid && grp_kind == `SMR_MSG_REPORT);
  c_accept: cover property (rx_accept);
  c_send: cover property ($rose(tx_start));
endmodule  // smr_socket_properties
bind smr_socket smr_socket_properties #(.REPORT_CYC(REPORT_CYC)) smr_chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .tx_start,
  .tx_dest_ip, .rx_valid, .rx_proto, .rx_fragment, .rx_accept, .grp_valid, .grp_kind,
  .grp_ready);

// file: testbench/smr_net_model.sv
`timescale 1ns/1ps
`include "smr_defines.vh"
// far side: finishes frames, takes group messages, offers packets
module smr_net_model (
  input  logic        pclk,        // clock
  input  logic        tx_start,    // send begins
  output logic        tx_done,     // frame finished
  input  logic        grp_valid,   // group message pending
  input  logic [1:0]  grp_kind,    // its kind
  output logic        grp_ready,   // message taken
  output logic        rx_valid,    // packet offered
  output logic [7:0]  rx_proto,    // its protocol
  output logic [31:0] rx_src_ip,   // its sender
  output logic [15:0] rx_len,      // its length
  output logic        rx_fragment  // it is a fragment
);
  int seed      = 54;  // fixed seed for wire delays and group message take delays
  int tx_wait   = 0;   // cycles left on the wire
  int grp_wait  = 0;   // cycles before taking a message
  int cnt_join  = 0;   // joins seen
  int cnt_leave = 0;   // leaves seen
  int cnt_rep   = 0;   // reports seen
  initial {tx_done, grp_ready, rx_valid, rx_proto, rx_src_ip, rx_len, rx_fragment} = '0;
  // finish each frame after a random wire time
  always @(posedge pclk) begin
    tx_done <= 1'b0;
    if (tx_start) tx_wait = 2 + ($random(seed) & 7);
    else if (tx_wait > 0) begin
      tx_wait = tx_wait - 1;
      if (tx_wait == 0) tx_done <= 1'b1;
    end
  end
  // take group messages promptly or slowly and count them by kind
  always @(posedge pclk) begin
    grp_ready <= 1'b0;
    if (grp_valid && grp_ready) begin
      grp_wait = $random(seed) & 3;
      cnt_join += (grp_kind == `SMR_MSG_JOIN);
      cnt_leave += (grp_kind == `SMR_MSG_LEAVE);
      cnt_rep += (grp_kind == `SMR_MSG_REPORT);
    end else if (grp_valid && grp_wait == 0) grp_ready <= 1'b1;
    else if (grp_valid) grp_wait--;
  end
  // offer one packet for a cycle, then scramble the released lines
  task automatic offer(input logic [7:0] p, input logic [31:0] ip, input logic [15:0] n,
                       input logic f);
    @(posedge pclk);
    {rx_valid, rx_proto, rx_src_ip, rx_len, rx_fragment} <= {1'b1, p, ip, n, f};
    @(posedge pclk);
    {rx_valid, rx_proto, rx_src_ip, rx_len, rx_fragment} <= {1'b0, ~p, ~ip, ~n, ~f};
  endtask
endmodule  // smr_net_model

// file: testbench/smr_socket_bench.sv
`timescale 1ns/1ps
`include "smr_defines.vh"
module smr_socket_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;  // bus and clock
  logic        tx_start, tx_raw_frame, tx_done, rx_valid, rx_fragment, rx_accept;
  logic        grp_valid, grp_ready;  // group handshake
  logic [1:0]  grp_kind;              // group message kind
  logic [11:0] paddr;                 // bus address
  logic [31:0] pwdata, prdata, tx_dest_ip, rx_src_ip;
  logic [7:0]  tx_proto, rx_proto, proto;
  logic [47:0] tx_dest_hw, rx_header;
  logic [15:0] tx_dest_port, tx_len, rx_len, wptr, n;
  logic [31:0] exp_rd[$];   // expected read data
  logic [47:0] exp_hdr[$];  // expected receive headers
  logic [15:0] exp_len[$];  // expected send lengths
  int miscompares, comparisons, seed, cycles, i;
  smr_socket #(.REPORT_CYC(50), .SOCKET_ID(0)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_start, .tx_proto, .tx_dest_hw,
    .tx_dest_ip, .tx_dest_port, .tx_len, .tx_raw_frame, .tx_done, .rx_valid, .rx_proto,
    .rx_src_ip, .rx_len, .rx_fragment, .rx_accept, .rx_header, .grp_valid, .grp_kind,
    .grp_ready);
  smr_net_model net_u (.pclk, .tx_start, .tx_done, .grp_valid, .grp_kind, .grp_ready,
    .rx_valid, .rx_proto, .rx_src_ip, .rx_len, .rx_fragment);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one bus transfer: setup, then access until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, `SMR_CMD_OFF, {24'h0, c});
  endtask
  // host bumps the write pointer, sends, and waits for the frame to finish
  task automatic send(input logic [15:0] len);
    rd(`SMR_TXFREE_OFF, {16'h0, `SMR_TX_BUF_BYTES});
    wptr = wptr + len;
    exp_len.push_back(len);
    apb(1'b1, `SMR_TXWR_OFF, {16'h0, wptr});
    cmd(`SMR_CMD_SEND);
    for (i = 0; i < 40 && tx_done !== 1'b1; i++) @(posedge pclk);
    chk({47'h0, tx_done}, 48'h1);
    repeat (2) @(posedge pclk);
  endtask
  // results at the ports against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) chk({16'h0, prdata}, {16'h0, exp_rd.pop_front()});
    if (psel && penable && pready === 1'b1) chk({47'h0, pslverr}, {47'h0, paddr > 12'h03C});
    if (tx_start === 1'b1) chk({32'h0, tx_len}, {32'h0, exp_len.pop_front()});
    if (rx_accept === 1'b1) chk(rx_header, exp_hdr.pop_front());
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    {seed, miscompares, comparisons, cycles, wptr} = {32'd54, 96'h0, 16'h0};
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // multicast group 239.1.1.11 on 01:00:5e:01:01:0b, port 8080
    apb(1'b1, `SMR_DHW_HI_OFF, 32'h0000_0100);
    apb(1'b1, `SMR_DHW_LO_OFF, 32'h5E01_010B);
    apb(1'b1, `SMR_DIP_OFF, 32'hEF01_010B);
    apb(1'b1, `SMR_PORT_OFF, 32'h0000_1F90);
    apb(1'b1, `SMR_DPORT_OFF, 32'h0000_1F90);
    apb(1'b1, `SMR_MODE_OFF, 32'h0000_0082);
    cmd(`SMR_CMD_OPEN);
    rd(`SMR_STATE_OFF, {24'h0, `SMR_ST_UDP});
    repeat (20) @(posedge pclk);
    chk(48'(net_u.cnt_join), 48'h1);
    n = 16'h1 + 16'($random(seed) & 32'h3FF);
    send(n);
    chk({16'h0, tx_dest_ip}, 48'hEF01_010B);
    chk({32'h0, tx_dest_port}, 48'h1F90);
    chk(tx_dest_hw, 48'h0100_5E01_010B);
    rd(`SMR_IRQ_OFF, 32'h10);
    apb(1'b1, `SMR_IRQ_OFF, 32'h10);
    rd(`SMR_IRQ_OFF, 32'h0);
    repeat (110) @(posedge pclk);
    chk(48'(net_u.cnt_rep >= 2), 48'h1);
    cmd(`SMR_CMD_CLOSE);
    repeat (20) @(posedge pclk);
    chk(48'(net_u.cnt_leave), 48'h1);
    // ip raw open refused for the tcp and udp numbers
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `SMR_PROTO_OFF, k ? 32'h11 : 32'h06);
      apb(1'b1, `SMR_MODE_OFF, 32'h03);
      cmd(`SMR_CMD_OPEN);
      rd(`SMR_STATE_OFF, 32'h0);
    end
    proto = 8'h80 | 8'($random(seed));
    apb(1'b1, `SMR_PROTO_OFF, {24'h0, proto});
    apb(1'b1, `SMR_DIP_OFF, 32'h0A00_0005);
    cmd(`SMR_CMD_OPEN);
    rd(`SMR_STATE_OFF, {24'h0, `SMR_ST_IPRAW});
    send(16'h0040);
    chk({40'h0, tx_proto}, {40'h0, proto});
    // receive filter, fragment and free space boundary
    net_u.offer(proto, 32'hC0A8_0001, 16'h07FB, 1'b0);
    net_u.offer(proto, 32'hC0A8_0001, 16'h0010, 1'b1);
    net_u.offer(proto ^ 8'h01, 32'hC0A8_0001, 16'h0010, 1'b0);
    exp_hdr.push_back({32'hC0A8_0001, 16'h07FA});
    net_u.offer(proto, 32'hC0A8_0001, 16'h07FA, 1'b0);
    net_u.offer(proto, 32'hC0A8_0002, 16'h0001, 1'b0);
    rd(`SMR_RXDROP_OFF, 32'h4);
    cmd(`SMR_CMD_RECV);
    exp_hdr.push_back({32'hC0A8_0003, 16'h0001});
    net_u.offer(proto, 32'hC0A8_0003, 16'h0001, 1'b0);
    cmd(`SMR_CMD_CLOSE);
    // mac raw needs only the mode and open
    apb(1'b1, `SMR_MODE_OFF, 32'h04);
    cmd(`SMR_CMD_OPEN);
    rd(`SMR_STATE_OFF, {24'h0, `SMR_ST_MACRAW});
    send(16'h003C);
    chk({47'h0, tx_raw_frame}, 48'h1);
    cmd(`SMR_CMD_CLOSE);
    rd(`SMR_STATE_OFF, 32'h0);
    // unmapped word reads zero and flags a slave error
    rd(12'h040, 32'h0);
    conclude();
  end
endmodule  // smr_socket_bench
